// *** led_fault_supervisor.sv ***
// fault supervisor: start-up sequence, fault recovery timing, status flags, string fault tracking
// assumes analog comparator results arrive as asynchronous pins and software uses the plain register port
`timescale 1ns/1ps

//Contract
// - pump output low while running: outputs off, pump flag, interrupt, retry after 100 ms.
// - bad pump capacitor at init: pump off, both pump flags, interrupt, retry 100 ms.
// - config check failure at init sets its flag and interrupt, operation continues.
// - feedback above low overvoltage: flag, stop switching, no recovery.
// - feedback high overvoltage or output_pin_a node over limit: flag, interrupt, recovery.
// - feedback undervoltage for 110 ms from boost start: overcurrent flag, interrupt, recovery.
// - bad string resistor at init: flag, default six channels at 200 mA.
// - resistors evaluated only at initialization, settings kept latched afterwards.
// - bad mode resistor: flag, default phase-shift dimming, address 0x2A.
// - bad frequency resistor: flag, default boost 400 kHz or dimming 305 Hz.
// - current-set short: current code becomes a quarter of programmed value.
// - current-set short sets flag and interrupt; restore programmed value on recovery.
// - over-temperature: outputs off, flag, interrupt; restart after hysteresis cooling.
// - boost at maximum with a used output low: flag open, remove, disable.
// - each new string fault sets summary flag and interrupt unless disabled.
// - per-string detail bits held until power-down; summary cleared by software.
// - output above short level while another in window: flag short, remove, disable.
// - grouped with boost at minimum and output above headroom plus hysteresis: short.
// - cycle-by-cycle current limit only cuts pulses, never a fault.
// - input overcurrent disables all strings and enters recovery.
module led_fault_supervisor
	import led_fault_pkg::*;
#(
	parameter int RESTART_CYCLES = RESTART_CYC,
	parameter int UVP_CYCLES     = UVP_CYC
)
(
	input  wire logic                     clk_sys,
	input  wire logic                     resetn,
	input  wire logic                     ce,
	input  wire led_fault_pkg::pins_t     pins,
	input  wire logic [led_fault_pkg::AW-1:0] addr,
	input  wire logic [led_fault_pkg::DW-1:0] wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic [led_fault_pkg::DW-1:0]  rdata,
	output logic                          int_n,
	output logic                          pump_en,
	output logic                          fet_en,
	output logic                          boost_en,
	output logic                          boost_switch_en,
	output logic [led_fault_pkg::NCH-1:0] led_en,
	output logic [led_fault_pkg::NCH-1:0] adapt_mask,
	output logic [11:0]                   sink_current_code,
	output led_fault_pkg::cfg_t           cfg
);
	import led_fault_pkg::*;

	// strings in use for a string configuration code: 0 means all six
	function automatic logic [NCH-1:0] used_mask(input logic [2:0] code);
		logic [NCH-1:0] m;
		m = '1;
		if (code != 3'h0 && code < 3'h6)
			m = m >> code;
		return m;
	endfunction

	pins_t              s1_r;
	pins_t              p;
	state_t             state_r;
	state_t             state_nxt;
	logic [TMR_W-1:0]   rec_cnt_r;
	logic [TMR_W-1:0]   uvp_cnt_r;
	logic               cfg_done_r;
	flags_t             flags_r;
	flags_t             set_v;
	flags_t             clr_v;
	flags_t             irq_v;
	logic [NCH-1:0]     chan_fault_r;
	logic               open_any_r;
	logic               short_any_r;
	logic               led_int_dis_r;
	logic [11:0]        prog_r;
	logic               current_set_pin_red_r;
	logic               boosting;
	logic               active;
	logic               in_init;
	logic [1:0]         fill_r;
	logic               uvp_expire;
	logic               trip;
	logic [NCH-1:0]     open_new;
	logic [NCH-1:0]     short_new;
	logic [NCH-1:0]     mask_nxt;
	logic               boost_nxt;

	// two-stage synchroniser on every comparator and strap pin
	// fill_r holds init back until both stages carry real pin levels, not reset zeros
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			s1_r   <= '0;
			p      <= '0;
			fill_r <= 2'b00;
		end
		else if (ce)
		begin
			s1_r   <= pins;
			p      <= s1_r;
			fill_r <= {fill_r[0], 1'b1};
		end
	end

	assign boosting = (state_r == ST_START) || (state_r == ST_RUN);
	assign active   = boosting || (state_r == ST_INIT);
	assign in_init  = (state_r == ST_INIT) && fill_r[1];

	assign uvp_expire = boosting && p.fb_uvp
		&& (uvp_cnt_r == TMR_W'(UVP_CYCLES - 1));

	// recovery causes while the boost runs
	assign trip = (active && p.pump_low)
		|| (boosting && (p.ovp_high || p.output_pin_a_ovp))
		|| uvp_expire
		|| (active && p.vin_ocp);

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_INIT:
			begin
				if (!fill_r[1])
					state_nxt = ST_INIT;
				else if (p.cap_bad || p.pump_low || p.vin_ocp)
					state_nxt = ST_RECOVER;
				else
					state_nxt = ST_START;
			end
			ST_START:
			begin
				if (trip)
					state_nxt = ST_RECOVER;
				else if (p.ss_done)
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				if (trip)
					state_nxt = ST_RECOVER;
			end
			ST_RECOVER:
			begin
				if (rec_cnt_r == TMR_W'(RESTART_CYCLES - 1))
					state_nxt = ST_INIT;
			end
			ST_THERMAL:
			begin
				if (p.cool && !p.hot)
					state_nxt = ST_INIT;
			end
		endcase
		if (p.hot && state_r != ST_THERMAL)
			state_nxt = ST_THERMAL;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			state_r <= ST_INIT;
		else if (ce)
			state_r <= state_nxt;
	end

	// counter is zero on every entry to recovery, so each retry waits the full delay
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			rec_cnt_r <= '0;
		else if (ce)
		begin
			if (state_r == ST_RECOVER && state_nxt == ST_RECOVER)
				rec_cnt_r <= rec_cnt_r + 1'b1;
			else
				rec_cnt_r <= '0;
		end
	end

	// undervoltage must persist without a break; any recovery of feedback restarts it
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			uvp_cnt_r <= '0;
		else if (ce)
		begin
			if (boosting && p.fb_uvp && !uvp_expire)
				uvp_cnt_r <= uvp_cnt_r + 1'b1;
			else
				uvp_cnt_r <= '0;
		end
	end

	// straps are taken once after reset; later retries keep them even if a resistor falls off
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			cfg_done_r <= 1'b0;
			cfg        <= '{STR_CFG_DEFAULT, MODE_DEFAULT, I2C_ADDR_DEFAULT,
				BOOST_FREQ_DEFAULT, PWM_FREQ_DEFAULT};
		end
		else if (ce && in_init && !cfg_done_r)
		begin
			cfg_done_r   <= 1'b1;
			cfg.str_code <= p.str_bad ? STR_CFG_DEFAULT : p.str_code;
			cfg.mode     <= p.mode_bad ? MODE_DEFAULT : p.mode_code;
			cfg.i2c_addr <= p.mode_bad ? I2C_ADDR_DEFAULT : p.addr_code;
			cfg.bfreq    <= p.bfreq_bad ? BOOST_FREQ_DEFAULT : p.bfreq_code;
			cfg.pfreq    <= p.pfreq_bad ? PWM_FREQ_DEFAULT : p.pfreq_code;
		end
	end

	// string fault detection
	always_comb
	begin
		open_new  = {NCH{state_r == ST_RUN && p.at_max}} & p.headroom_low & adapt_mask;
		short_new = {NCH{boosting}} & adapt_mask
			& ((p.over_short & {NCH{|p.in_window}})
			| (p.above_hys & {NCH{p.grouped && p.at_min}}));
		mask_nxt  = used_mask(cfg.str_code) & ~(chan_fault_r | open_new | short_new);
	end

	// detail bits have no clear path; only a power cycle resets them
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			chan_fault_r <= '0;
			open_any_r   <= 1'b0;
			short_any_r  <= 1'b0;
		end
		else if (ce)
		begin
			chan_fault_r <= chan_fault_r | open_new | short_new;
			open_any_r   <= open_any_r | (|open_new);
			short_any_r  <= short_any_r | (|short_new);
		end
	end

	always_comb
	begin
		set_v        = '0;
		set_v.cp     = (active && p.pump_low) || (in_init && p.cap_bad);
		set_v.cpcap  = in_init && p.cap_bad;
		set_v.crc    = in_init && p.crc_bad;
		set_v.ovpl   = boosting && p.ovp_low;
		set_v.ovph   = boosting && (p.ovp_high || p.output_pin_a_ovp);
		set_v.ocp    = uvp_expire;
		set_v.strcfg = in_init && !cfg_done_r && p.str_bad;
		set_v.mode   = in_init && !cfg_done_r && p.mode_bad;
		set_v.fset   = in_init && !cfg_done_r && (p.bfreq_bad || p.pfreq_bad);
		set_v.current_set_pin   = p.current_set_pin_short;
		set_v.tsd    = p.hot;
		set_v.led    = |((open_new | short_new) & ~chan_fault_r);
		set_v.vinocp = active && p.vin_ocp;
		clr_v        = '0;
		if (wr && addr == ADDR_STATUS)
			clr_v = flags_t'(wdata[FLAG_W-1:0]);
	end

	// set beats a clear written in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			flags_r <= '0;
		else if (ce)
			flags_r <= (flags_r & ~clr_v) | set_v;
	end

	// overvoltage-low and strap flags report status only
	always_comb
	begin
		irq_v        = flags_r;
		irq_v.ovpl   = 1'b0;
		irq_v.strcfg = 1'b0;
		irq_v.mode   = 1'b0;
		irq_v.fset   = 1'b0;
		irq_v.led    = flags_r.led && !led_int_dis_r;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			int_n <= 1'b1;
		else if (ce)
			int_n <= ~(|irq_v);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			led_int_dis_r <= LED_INT_DIS_RST;
			prog_r        <= CURRENT_RST;
		end
		else if (ce && wr)
		begin
			if (addr == ADDR_CTRL)
				led_int_dis_r <= wdata[0];
			if (addr == ADDR_CURRENT)
				prog_r <= wdata[11:0];
		end
	end

	// reduced current holds until the pin is back above its release level
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			current_set_pin_red_r <= 1'b0;
		else if (ce)
		begin
			if (p.current_set_pin_short)
				current_set_pin_red_r <= 1'b1;
			else if (p.current_set_pin_ok)
				current_set_pin_red_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			sink_current_code <= CURRENT_RST;
		else if (ce)
			sink_current_code <= (current_set_pin_red_r || p.current_set_pin_short) ? (prog_r >> 2) : prog_r;
	end

	assign boost_nxt = (state_nxt == ST_START) || (state_nxt == ST_RUN);

	// all power outputs follow the next state so they drop in the cycle the fault is seen
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			pump_en         <= 1'b0;
			fet_en          <= 1'b0;
			boost_en        <= 1'b0;
			boost_switch_en <= 1'b0;
			led_en          <= '0;
			adapt_mask      <= '0;
		end
		else if (ce)
		begin
			pump_en         <= (state_nxt == ST_INIT) || boost_nxt;
			fet_en          <= boost_nxt;
			boost_en        <= boost_nxt;
			boost_switch_en <= boost_nxt && !p.ovp_low && !p.cyc_limit;
			led_en          <= boost_nxt ? mask_nxt : '0;
			adapt_mask      <= mask_nxt;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			rdata <= '0;
		else if (ce)
		begin
			rdata <= '0;
			if (rd)
			begin
				unique case (addr)
					ADDR_STATUS:  rdata <= DW'(flags_r);
					ADDR_DETAIL:  rdata <= DW'({open_any_r, short_any_r, chan_fault_r});
					ADDR_CTRL:    rdata <= DW'({state_r, led_int_dis_r});
					ADDR_CURRENT: rdata <= DW'(prog_r);
					ADDR_CONFIG:  rdata <= DW'({cfg.str_code, cfg.mode, cfg.bfreq, cfg.pfreq});
					default:      rdata <= '0;
				endcase
			end
		end
	end

endmodule

// *** led_fault_pkg.sv ***
// constants, types and register map for the led driver fault supervisor
// assumes a single 20 MHz system clock shared with the register port
package led_fault_pkg;

	localparam int CLK_HZ     = 20_000_000;
	localparam int RESTART_MS = 100;
	localparam int UVP_MS     = 110;
	localparam int RESTART_CYC = CLK_HZ / 1000 * RESTART_MS;
	localparam int UVP_CYC     = CLK_HZ / 1000 * UVP_MS;
	localparam int TMR_W       = 22;

	localparam int NCH = 6;
	localparam int AW  = 4;
	localparam int DW  = 16;

	localparam logic [AW-1:0] ADDR_STATUS  = 4'h0;
	localparam logic [AW-1:0] ADDR_DETAIL  = 4'h1;
	localparam logic [AW-1:0] ADDR_CTRL    = 4'h2;
	localparam logic [AW-1:0] ADDR_CURRENT = 4'h3;
	localparam logic [AW-1:0] ADDR_CONFIG  = 4'h4;

	localparam logic [11:0] CURRENT_RST        = 12'hFFF;
	localparam logic [2:0]  STR_CFG_DEFAULT    = 3'h0;
	localparam logic [1:0]  MODE_DEFAULT       = 2'h0;
	localparam logic [6:0]  I2C_ADDR_DEFAULT   = 7'h2A;
	localparam logic [3:0]  BOOST_FREQ_DEFAULT = 4'h3;
	localparam logic [3:0]  PWM_FREQ_DEFAULT   = 4'h2;
	localparam logic        LED_INT_DIS_RST    = 1'b0;

	typedef enum logic [4:0] {
		ST_INIT    = 5'b00001,
		ST_START   = 5'b00010,
		ST_RUN     = 5'b00100,
		ST_RECOVER = 5'b01000,
		ST_THERMAL = 5'b10000
	} state_t;

	typedef struct packed {
		logic           pump_low;
		logic           cap_bad;
		logic           crc_bad;
		logic           ovp_low;
		logic           ovp_high;
		logic           output_pin_a_ovp;
		logic           fb_uvp;
		logic           ss_done;
		logic           cyc_limit;
		logic           vin_ocp;
		logic           hot;
		logic           cool;
		logic           current_set_pin_short;
		logic           current_set_pin_ok;
		logic           at_max;
		logic           at_min;
		logic           grouped;
		logic           str_bad;
		logic           mode_bad;
		logic           bfreq_bad;
		logic           pfreq_bad;
		logic [2:0]     str_code;
		logic [1:0]     mode_code;
		logic [6:0]     addr_code;
		logic [3:0]     bfreq_code;
		logic [3:0]     pfreq_code;
		logic [NCH-1:0] headroom_low;
		logic [NCH-1:0] over_short;
		logic [NCH-1:0] in_window;
		logic [NCH-1:0] above_hys;
	} pins_t;

	typedef struct packed {
		logic [2:0] str_code;
		logic [1:0] mode;
		logic [6:0] i2c_addr;
		logic [3:0] bfreq;
		logic [3:0] pfreq;
	} cfg_t;

	// bit 0 is vin_ocp, bit 12 is cp
	typedef struct packed {
		logic cp;
		logic cpcap;
		logic crc;
		logic ovpl;
		logic ovph;
		logic ocp;
		logic strcfg;
		logic mode;
		logic fset;
		logic current_set_pin;
		logic tsd;
		logic led;
		logic vinocp;
	} flags_t;

	localparam int FLAG_W = 13;

endpackage

// *** led_fault_supervisor_props.sv ***
// concurrent checks on the ports of the led fault supervisor
// assumes ce is held high, so a pin level reaches every output within five edges
`timescale 1ns/1ps
module led_fault_supervisor_props
	import led_fault_pkg::*;
(
	input wire logic                  clk_sys,
	input wire logic                  resetn,
	input wire led_fault_pkg::pins_t  pins,
	input wire logic                  int_n,
	input wire logic                  pump_en,
	input wire logic                  fet_en,
	input wire logic                  boost_en,
	input wire logic                  boost_switch_en,
	input wire logic [NCH-1:0]        led_en,
	input wire logic [11:0]           sink_current_code,
	input wire led_fault_pkg::cfg_t   cfg
);
	logic [2:0] since_rst_r;

	// straps settle during the first few cycles after release, so the hold check waits for them
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			since_rst_r <= 3'h0;
		else if (since_rst_r != 3'h7)
			since_rst_r <= since_rst_r + 3'h1;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_pump_low_off: assert property (pins.pump_low [*5] |-> !fet_en && !boost_en && led_en == '0)
		else $error("outputs left on while pump output is low");
	a_input_ocp_dark: assert property (pins.vin_ocp [*5] |-> led_en == '0 && !fet_en)
		else $error("strings left on during input overcurrent");
	a_thermal_all_off: assert property (pins.hot [*5] |-> !fet_en && !boost_en && !pump_en && led_en == '0)
		else $error("outputs left on while over temperature");
	a_ovp_low_stop: assert property (pins.ovp_low [*5] |-> !boost_switch_en)
		else $error("boost switching above low overvoltage");
	a_limit_cuts_pulse: assert property (pins.cyc_limit [*5] |-> !boost_switch_en)
		else $error("boost switching during current limit");
	a_current_set_pin_quarter_code: assert property (pins.current_set_pin_short [*6] |-> sink_current_code[11:10] == 2'b00 && !int_n)
		else $error("current code not reduced on current-set short");
	a_supply_off_dark: assert property (!fet_en |-> led_en == '0)
		else $error("strings enabled with supply switched off");
	a_straps_held: assert property (since_rst_r == 3'h7 |-> $stable(cfg))
		else $error("latched configuration changed after start");
endmodule

// *** led_host_model.sv ***
// host side of the supervisor: counts interrupt requests seen on the active-low line
// assumes the line is a registered level from the device, sampled on the system clock
`timescale 1ns/1ps
module led_host_model (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic int_n,
	output int        irq_count
);
	logic int_n_r;

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			int_n_r   <= 1'b1;
			irq_count <= 0;
		end
		else
		begin
			int_n_r <= int_n;
			if (int_n_r && !int_n)
				irq_count <= irq_count + 1;
		end
	end
endmodule

// *** led_fault_supervisor_bench.sv ***
// bench for the led fault supervisor: supply and boost faults, current-set short, string faults
// assumes the checker and host model are compiled first; counts are shortened by parameters
`timescale 1ns/1ps
module led_fault_supervisor_bench;
	import led_fault_pkg::*;
	localparam int RC = 20;
	localparam int UC = 30;
	localparam logic [DW-1:0] CFG_DEF = DW'({STR_CFG_DEFAULT, MODE_DEFAULT, BOOST_FREQ_DEFAULT, PWM_FREQ_DEFAULT});
	logic           clk_sys;
	logic           resetn;
	logic           ce;
	pins_t          p;
	logic [AW-1:0]  addr;
	logic [DW-1:0]  wdata;
	logic           wr;
	logic           rd;
	logic [DW-1:0]  rdata;
	logic           int_n;
	logic           pump_en;
	logic           fet_en;
	logic           boost_en;
	logic           bsw;
	logic [NCH-1:0] led_en;
	logic [NCH-1:0] adapt_mask;
	logic [11:0]    code;
	cfg_t           cfg;
	int             irq_count;
	int             err_total;
	int             samples_checked;
	int             n;
	int             lo;
	int             exp_irq;
	logic [15:0]    v;
	logic [15:0]    exp_detail;
	int             bitv [6] = '{12, 8, 8, 0, 7, 2};

	led_fault_supervisor #(.RESTART_CYCLES(RC), .UVP_CYCLES(UC)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
		.ce(ce), .pins(p), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .int_n(int_n),
		.pump_en(pump_en), .fet_en(fet_en), .boost_en(boost_en), .boost_switch_en(bsw), .led_en(led_en),
		.adapt_mask(adapt_mask), .sink_current_code(code), .cfg(cfg));
	led_host_model host_u (.clk_sys(clk_sys), .resetn(resetn), .int_n(int_n), .irq_count(irq_count));

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, want, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so they are taken just after that edge
	task automatic reg_chk(input string what, input logic [AW-1:0] a, input logic [DW-1:0] want);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		chk(what, rdata, want);
	endtask
	task automatic set_f(input int i, input logic b);
		case (i)
			0: p.pump_low <= b;
			1: p.ovp_high <= b;
			2: p.output_pin_a_ovp <= b;
			3: p.vin_ocp <= b;
			4: p.fb_uvp <= b;
			default:
			begin
				p.hot <= b;
				p.cool <= !b;
			end
		endcase
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	initial
	begin
		#(50 * 40000);
		err_total++;
		complete_run();
	end

	initial
	begin
		p = '0;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		resetn = 1'b0;
		ce = 1'b1;
		err_total = 0;
		samples_checked = 0;
		exp_irq = 0;
		exp_detail = '0;
		v = $urandom(32'h96B4);
		tick(16);
		resetn <= 1'b1;
		tick(2);
		reg_chk("status", ADDR_STATUS, 16'h0000);
		reg_chk("current", ADDR_CURRENT, 16'h0FFF);
		chk("int_n", int_n, 1'b1);
		p.ss_done <= 1'b1;
		p.crc_bad <= 1'b1;
		tick(6);
		reg_chk("state", ADDR_CTRL, 16'h0008);
		chk("led_en", {adapt_mask, led_en}, 12'hFFF);
		// the config check fails at every retry, so its flag joins each fault
		for (int i = 0; i < 6; i++)
		begin
			set_f(i, 1'b1);
			n = (i == 4) ? UC + 8 : 5;
			tick(n);
			chk("outputs", {fet_en, boost_en, led_en}, 8'h00);
			chk("int_n", int_n, 1'b0);
			set_f(i, 1'b0);
			while (fet_en !== 1'b1 && n < 400)
			begin
				tick(1);
				n++;
			end
			lo = ((i == 4) ? UC : 0) + ((i == 5) ? 0 : RC);
			chk("restart", n >= lo && n <= lo + 16, 1'b1);
			tick(4);
			reg_chk("status", ADDR_STATUS, (16'h0001 << bitv[i]) | 16'h0400);
			reg_wr(ADDR_STATUS, 16'h1FFF);
			tick(2);
			chk("int_n", int_n, 1'b1);
			exp_irq++;
		end
		reg_chk("state", ADDR_CTRL, 16'h0008);
		p.ovp_low <= 1'b1;
		tick(5);
		chk("switch", bsw, 1'b0);
		p.ovp_low <= 1'b0;
		p.cyc_limit <= 1'b1;
		tick(5);
		chk("switch", {bsw, int_n}, 2'b01);
		p.cyc_limit <= 1'b0;
		tick(4);
		chk("switch", {bsw, int_n}, 2'b11);
		reg_chk("status", ADDR_STATUS, 16'h0200);
		reg_wr(ADDR_STATUS, 16'h1FFF);
		for (int j = 0; j < 2; j++)
		begin
			v = j ? ($urandom & 16'h0FFF) : 16'h0FFF;
			if (j)
				reg_wr(ADDR_CURRENT, v);
			p.current_set_pin_short <= 1'b1;
			tick(6);
			chk("quarter", code, v >> 2);
			chk("int_n", int_n, 1'b0);
			p.current_set_pin_short <= 1'b0;
			p.current_set_pin_ok <= 1'b1;
			tick(6);
			chk("restore", code, v);
			reg_chk("status", ADDR_STATUS, 16'h0008);
			reg_wr(ADDR_STATUS, 16'h1FFF);
			exp_irq++;
		end
		// open, shorted, then grouped short with string interrupts disabled
		for (int k = 0; k < 3; k++)
		begin
			if (k == 2)
				reg_wr(ADDR_CTRL, 16'h0001);
			p.at_max <= (k == 0);
			p.headroom_low <= (k == 0) ? 6'h04 : 6'h00;
			p.in_window <= (k == 1) ? 6'h01 : 6'h00;
			p.over_short <= (k == 1) ? 6'h10 : 6'h00;
			p.grouped <= (k == 2);
			p.at_min <= (k == 2);
			p.above_hys <= (k == 2) ? 6'h20 : 6'h00;
			exp_detail |= (k == 0) ? 16'h0084 : ((k == 1) ? 16'h0050 : 16'h0060);
			tick(6);
			reg_chk("detail", ADDR_DETAIL, exp_detail);
			chk("strings", {adapt_mask, led_en}, {2{6'h3F & ~exp_detail[5:0]}});
			chk("int_n", int_n, k == 2);
			reg_chk("status", ADDR_STATUS, 16'h0002);
			reg_wr(ADDR_STATUS, 16'h1FFF);
			if (k < 2)
				exp_irq++;
		end
		reg_wr(ADDR_CTRL, 16'h0000);
		tick(3);
		chk("irq count", irq_count, exp_irq);
		// second power-up with a bad pump capacitor and every strap bad; the straps carry odd codes
		resetn <= 1'b0;
		p <= '0;
		tick(4);
		p.cap_bad <= 1'b1;
		p.str_bad <= 1'b1;
		p.mode_bad <= 1'b1;
		p.bfreq_bad <= 1'b1;
		p.pfreq_bad <= 1'b1;
		p.str_code <= 3'h2;
		p.mode_code <= 2'h1;
		p.addr_code <= 7'h11;
		p.bfreq_code <= 4'h9;
		p.pfreq_code <= 4'h7;
		p.ss_done <= 1'b1;
		tick(4);
		resetn <= 1'b1;
		tick(8);
		chk("pump", {pump_en, fet_en, int_n}, 3'b000);
		reg_chk("config", ADDR_CONFIG, CFG_DEF);
		chk("address", cfg.i2c_addr, I2C_ADDR_DEFAULT);
		reg_chk("status", ADDR_STATUS, 16'h1870);
		p.cap_bad <= 1'b0;
		tick(RC);
		chk("strings", {adapt_mask, led_en}, 12'hFFF);
		// a resistor that turns good after start-up must not be taken at the thermal restart
		p.str_bad <= 1'b0;
		p.hot <= 1'b1;
		tick(5);
		p.hot <= 1'b0;
		p.cool <= 1'b1;
		tick(8);
		reg_chk("config", ADDR_CONFIG, CFG_DEF);
		chk("strings", {adapt_mask, led_en}, 12'hFFF);
		// with the clock enable low a register write is lost
		ce <= 1'b0;
		reg_wr(ADDR_CURRENT, 16'h0123);
		ce <= 1'b1;
		reg_chk("frozen", ADDR_CURRENT, 16'h0FFF);
		complete_run();
	end
endmodule

bind led_fault_supervisor led_fault_supervisor_props chk_u (.clk_sys(clk_sys), .resetn(resetn), .pins(pins),
	.int_n(int_n), .pump_en(pump_en), .fet_en(fet_en), .boost_en(boost_en), .boost_switch_en(boost_switch_en),
	.led_en(led_en), .sink_current_code(sink_current_code), .cfg(cfg));
